// ===== rtl/adc_seq_pkg.sv
// Purpose: Shared constants and types of the delta-sigma converter sequencer
// Assumes: 200 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   Register offsets are byte addresses, one aligned word each
package adc_seq_pkg;

	localparam int CLK_HZ      = 200_000_000;
	localparam int NOM_BITS    = 12;
	localparam int NOM_SPS     = 192_000;
	localparam int DECIM_NOM   = 1024;
	// Clock cycles per modulator bit at the nominal rate, rounded down
	localparam int MOD_DIV_RAW = CLK_HZ / (NOM_SPS * DECIM_NOM);
	localparam int MOD_DIV     = (MOD_DIV_RAW < 1) ? 1 : MOD_DIV_RAW;
	localparam int DIV_W       = 8;

	localparam int DEC_W       = 16;
	localparam int RES_W       = 24;
	localparam int AVG_W       = 8;
	localparam int MUX_W       = 4;
	localparam int FILL_N      = 4;
	localparam int FILL_W      = 3;

	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_RESULT   = 8'h08;
	localparam logic [7:0] OFS_DECIM    = 8'h0C;
	localparam logic [7:0] OFS_AVG      = 8'h10;
	localparam logic [7:0] OFS_INT_STAT = 8'h14;
	localparam logic [7:0] OFS_INT_MASK = 8'h18;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MUX_LSB  = 2;
	localparam int CTRL_START    = 8;
	localparam int CTRL_STOP     = 9;
	localparam int STAT_EOC      = 0;
	localparam int STAT_BUSY     = 1;

	localparam int INT_W    = 2;
	localparam int INT_DONE = 0;
	localparam int INT_OVR  = 1;

	localparam logic [DEC_W-1:0] DECIM_RST = 16'h0400;
	localparam logic [AVG_W-1:0] AVG_RST   = 8'h10;

	typedef enum logic [1:0]
	{
		MODE_SINGLE = 2'h0,
		MODE_FAST   = 2'h1,
		MODE_CONT   = 2'h2,
		MODE_AVG    = 2'h3
	} mode_t;

	typedef enum logic [3:0]
	{
		ST_IDLE  = 4'h1,
		ST_FLUSH = 4'h2,
		ST_RUN   = 4'h4,
		ST_HOLD  = 4'h8
	} state_t;

endpackage

// ===== rtl/adc_link_if.sv
// Purpose: Carries modulator bits, decimator results and averager results
// Assumes: All signals in the clk_i domain
// Notes:   One modport per party of the converter channel
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
	import adc_seq_pkg::*;
	logic                tick;
	logic                mod_bit;
	logic                clear;
	logic [DEC_W-1:0]    ratio;
	logic [DEC_W-1:0]    res;
	logic                res_v;
	logic                avg_clear;
	logic [AVG_W-1:0]    avg_n;
	logic [RES_W-1:0]    avg_res;
	logic                avg_v;

	modport seq (output tick, mod_bit, clear, ratio, avg_clear, avg_n,
		input res, res_v, avg_res, avg_v);
	modport dec (input tick, mod_bit, clear, ratio, output res, res_v);
	modport avg (input res, res_v, avg_clear, avg_n, output avg_res, avg_v);
endinterface
`default_nettype wire

// ===== rtl/adc_decimator.sv
// Purpose: Turns the oversampled modulator bit stream into parallel results
// Assumes: One modulator bit per tick; ratio is bits per window
// Notes:   Output is the sum of the last four windows
`timescale 1ns/1ps
`default_nettype none
module adc_decimator
(
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	adc_link_if.dec     lnk
);
	import adc_seq_pkg::*;

	logic [DEC_W-1:0]  cnt_q;
	logic [DEC_W-1:0]  ones_q;
	logic [DEC_W-1:0]  win_q [3];
	logic [FILL_W-1:0] fill_q;
	logic [DEC_W-1:0]  cur;
	logic [DEC_W+1:0]  sum;
	logic              wend;
	logic              full;

	// Window length follows the ratio; result width is fixed at DEC_W bits, saturating
	assign wend = lnk.tick && (cnt_q >= lnk.ratio - 16'h0001);
	assign cur  = ones_q + {{(DEC_W-1){1'b0}}, lnk.mod_bit};
	assign sum  = {2'b00, cur} + {2'b00, win_q[0]} + {2'b00, win_q[1]} + {2'b00, win_q[2]};
	assign full = (fill_q >= FILL_W'(FILL_N - 1));

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q     <= '0;
			ones_q    <= '0;
			fill_q    <= '0;
			lnk.res   <= '0;
			lnk.res_v <= 1'b0;
		end
		else
		begin
			lnk.res_v <= 1'b0;
			if (lnk.clear)
			begin
				cnt_q  <= '0;
				ones_q <= '0;
				fill_q <= '0;
			end
			else if (wend)
			begin
				cnt_q  <= '0;
				ones_q <= '0;
				if (!full)
					fill_q <= fill_q + 3'h1;
				else
					fill_q <= FILL_W'(FILL_N);
				if (full)
				begin
					// From the fourth window after a clear on, every window gives a valid code
					lnk.res_v <= 1'b1;
					lnk.res   <= (|sum[DEC_W+1:DEC_W]) ? '1 : sum[DEC_W-1:0];
				end
			end
			else if (lnk.tick)
			begin
				cnt_q  <= cnt_q + 16'h0001;
				ones_q <= cur;
			end
		end
	end

	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_win
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
					win_q[i] <= '0;
				else if (lnk.clear)
					win_q[i] <= '0;
				else if (wend)
					win_q[i] <= (i == 0) ? cur : win_q[(i == 0) ? 0 : i-1];
			end
		end
	endgenerate

	full_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.res_v |-> fill_q == FILL_W'(FILL_N))
		else $error("decimator result before four windows");
	clear_fill_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.clear |=> !lnk.res_v && fill_q == '0)
		else $error("decimator history not flushed");

endmodule
`default_nettype wire

// ===== rtl/adc_avg_sinc1.sv
// Purpose: First-order sinc post filter for the averaging mode
// Assumes: avg_n of zero behaves as one
// Notes:   Sums avg_n decimator results into a wider result
`timescale 1ns/1ps
`default_nettype none
module adc_avg_sinc1
(
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	adc_link_if.avg     lnk
);
	import adc_seq_pkg::*;

	logic [RES_W-1:0] acc_q;
	logic [AVG_W-1:0] cnt_q;
	logic [AVG_W-1:0] last;
	logic [RES_W-1:0] nxt;
	logic             done;

	assign last = (lnk.avg_n == '0) ? '0 : lnk.avg_n - 8'h01;
	assign nxt  = acc_q + {{(RES_W-DEC_W){1'b0}}, lnk.res};
	assign done = lnk.res_v && (cnt_q >= last);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			acc_q       <= '0;
			cnt_q       <= '0;
			lnk.avg_res <= '0;
			lnk.avg_v   <= 1'b0;
		end
		else
		begin
			lnk.avg_v <= done && !lnk.avg_clear;
			if (lnk.avg_clear || done)
			begin
				acc_q <= '0;
				cnt_q <= '0;
			end
			else if (lnk.res_v)
			begin
				acc_q <= nxt;
				cnt_q <= cnt_q + 8'h01;
			end
			if (done)
				lnk.avg_res <= nxt;
		end
	end

	avg_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.avg_v |-> $past(cnt_q) == $past(last))
		else $error("averaged result after wrong count");

endmodule
`default_nettype wire

// ===== rtl/adc_sequencer.sv
// Purpose: Conversion sequencer, decimator control and AHB-Lite registers
// Assumes: Modulator delivers one bit per mod_clk_en_o pulse; soc_i synchronous
// Notes:   Zero-wait-state slave, always OKAY; unmapped reads return zero
// Notes on behaviour
// - One operating mode at a time: single, fast filter, continuous or averaging.
// - Start bit write or start strobe begins a sequence in every mode.
// - End of conversion sets status and output, held until result is read.
// - Results depend on last four windows; invalid until fourth after input switch.
// - Single mode: standby, one conversion, capture, hold until read, standby.
// - Continuous mode resets the channel once, then runs until stopped.
// - Fast filter mode resets the channel and restarts after each result.
// - Averaging mode never resets the modulator between intermediate results.
// - Averaging mode sums decimator results in a sinc1 filter, into 24 bits.
// - Decimator converts the bit stream; its ratio sets resolution and rate.
// - Nominal setting gives 12-bit results at 192 ksps.
// - Start strobe is optional; continuous mode runs with it tied low.
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer
(
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       hsel_i,
	input  wire logic [31:0]                haddr_i,
	input  wire logic [1:0]                 htrans_i,
	input  wire logic                       hwrite_i,
	input  wire logic [2:0]                 hsize_i,
	input  wire logic [31:0]                hwdata_i,
	input  wire logic                       hready_i,
	output logic      [31:0]                hrdata_o,
	output logic                            hreadyout_o,
	output logic                            hresp_o,
	input  wire logic                       soc_i,
	input  wire logic                       mod_bit_i,
	output logic                            mod_clk_en_o,
	output logic                            mod_rst_o,
	output logic      [adc_seq_pkg::MUX_W-1:0] mux_sel_o,
	output logic                            eoc_o,
	output logic                            irq_o
);
	import adc_seq_pkg::*;

	adc_link_if lnk ();

	adc_decimator u_dec
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lnk   (lnk.dec)
	);

	adc_avg_sinc1 u_avg
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lnk   (lnk.avg)
	);

	state_t            state_q;
	state_t            state_d;
	mode_t             mode_q;
	mode_t             run_mode_q;
	logic [MUX_W-1:0]  mux_q;
	logic [DEC_W-1:0]  decim_q;
	logic [AVG_W-1:0]  avg_n_q;
	logic [RES_W-1:0]  result_q;
	logic              eoc_q;
	logic [INT_W-1:0]  int_stat_q;
	logic [INT_W-1:0]  int_mask_q;
	logic [DIV_W-1:0]  div_q;
	logic              soc_q;
	logic              ap_wr_q;
	logic [7:0]        ap_addr_q;
	logic [31:0]       hrdata_q;
	mode_t             mode_new;

	// Bus decode
	wire               ap_go    = hsel_i && htrans_i[1] && hready_i;
	wire               ap_rd    = ap_go && !hwrite_i;
	wire               wr_ctrl  = ap_wr_q && (ap_addr_q == OFS_CTRL);
	wire               wr_decim = ap_wr_q && (ap_addr_q == OFS_DECIM);
	wire               wr_avg   = ap_wr_q && (ap_addr_q == OFS_AVG);
	wire               wr_istat = ap_wr_q && (ap_addr_q == OFS_INT_STAT);
	wire               wr_imask = ap_wr_q && (ap_addr_q == OFS_INT_MASK);
	wire               rd_res   = ap_rd && (haddr_i[7:0] == OFS_RESULT);
	wire [MUX_W-1:0]   mux_new  = hwdata_i[CTRL_MUX_LSB +: MUX_W];
	wire               mux_chg  = wr_ctrl && (mux_new != mux_q);

	// Triggers
	wire               soc_edge = soc_i && !soc_q;
	wire               start    = (wr_ctrl && hwdata_i[CTRL_START]) || soc_edge;
	wire               stop     = wr_ctrl && hwdata_i[CTRL_STOP];
	wire               busy     = (state_q != ST_IDLE);

	// Result posting
	wire               in_run   = (state_q == ST_RUN);
	wire               post_dec = in_run && (run_mode_q != MODE_AVG) && lnk.res_v;
	wire               post_avg = in_run && (run_mode_q == MODE_AVG) && lnk.avg_v;
	wire               post     = (post_dec || post_avg) && !stop;
	wire [RES_W-1:0]   post_val = post_avg ? lnk.avg_res
		: {{(RES_W-DEC_W){1'b0}}, lnk.res};

	wire [31:0]        rd_mux =
		(haddr_i[7:0] == OFS_CTRL)     ? {22'h0, 2'b00, 2'b00, mux_q, mode_q} :
		(haddr_i[7:0] == OFS_STATUS)   ? {30'h0, busy, eoc_q} :
		(haddr_i[7:0] == OFS_RESULT)   ? {8'h00, result_q} :
		(haddr_i[7:0] == OFS_DECIM)    ? {16'h0000, decim_q} :
		(haddr_i[7:0] == OFS_AVG)      ? {24'h000000, avg_n_q} :
		(haddr_i[7:0] == OFS_INT_STAT) ? {30'h0, int_stat_q} :
		(haddr_i[7:0] == OFS_INT_MASK) ? {30'h0, int_mask_q} : 32'h0000_0000;

	// Channel connections
	assign lnk.tick      = (div_q == '0);
	assign lnk.mod_bit   = mod_bit_i;
	// A new input selection flushes the decimator history
	assign lnk.clear     = (state_q == ST_FLUSH) || !busy || mux_chg;
	assign lnk.ratio     = decim_q;
	assign lnk.avg_clear = lnk.clear;
	assign lnk.avg_n     = avg_n_q;
	// A start written together with a mode runs in that mode
	assign mode_new      = mode_t'(hwdata_i[CTRL_MODE_LSB +: 2]);

	assign hrdata_o      = hrdata_q;
	assign hreadyout_o   = 1'b1;
	assign hresp_o       = 1'b0;
	assign mod_clk_en_o  = lnk.tick;
	// Modulator reset only in the flush state, so averaging sees one only at its start
	assign mod_rst_o     = (state_q == ST_FLUSH);
	assign mux_sel_o     = mux_q;
	assign eoc_o         = eoc_q;
	assign irq_o         = |(int_stat_q & int_mask_q);

	// Sequencer
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
				if (start)
					state_d = ST_FLUSH;
			ST_FLUSH:
				state_d = stop ? ST_IDLE : ST_RUN;
			ST_RUN:
				if (stop)
					state_d = ST_IDLE;
				else if (post)
				begin
					unique case (run_mode_q)
						MODE_SINGLE: state_d = ST_HOLD;
						MODE_FAST:   state_d = ST_FLUSH;
						MODE_CONT:   state_d = ST_RUN;
						MODE_AVG:    state_d = ST_RUN;
					endcase
				end
			ST_HOLD:
				if (rd_res || !eoc_q || stop)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q    <= ST_IDLE;
			run_mode_q <= MODE_SINGLE;
			soc_q      <= 1'b0;
			div_q      <= '0;
		end
		else
		begin
			state_q <= state_d;
			soc_q   <= soc_i;
			div_q   <= (div_q >= DIV_W'(MOD_DIV - 1)) ? '0 : div_q + 8'h01;
			if (state_q == ST_IDLE && start)
				run_mode_q <= wr_ctrl ? mode_new : mode_q;
		end
	end

	// Registers and bus
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= '0;
			hrdata_q  <= '0;
			mode_q    <= MODE_SINGLE;
			mux_q     <= '0;
			decim_q   <= DECIM_RST;
			avg_n_q   <= AVG_RST;
			int_mask_q <= '0;
		end
		else
		begin
			ap_wr_q   <= ap_go && hwrite_i;
			ap_addr_q <= haddr_i[7:0];
			if (ap_rd)
				hrdata_q <= rd_mux;
			if (wr_ctrl)
			begin
				mode_q <= mode_new;
				mux_q  <= mux_new;
			end
			if (wr_decim)
				decim_q <= hwdata_i[DEC_W-1:0];
			if (wr_avg)
				avg_n_q <= hwdata_i[AVG_W-1:0];
			if (wr_imask)
				int_mask_q <= hwdata_i[INT_W-1:0];
		end
	end

	// End of conversion and sticky events; a new post wins over a clear
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			result_q   <= '0;
			eoc_q      <= 1'b0;
			int_stat_q <= '0;
		end
		else
		begin
			if (post)
			begin
				result_q <= post_val;
				eoc_q    <= 1'b1;
			end
			else if (rd_res)
				eoc_q <= 1'b0;
			int_stat_q[INT_DONE] <= post
				|| (int_stat_q[INT_DONE] && !(wr_istat && hwdata_i[INT_DONE]));
			int_stat_q[INT_OVR]  <= (post && eoc_q && !rd_res)
				|| (int_stat_q[INT_OVR] && !(wr_istat && hwdata_i[INT_OVR]));
		end
	end

	// Checks
	sequence single_post_s;
		in_run && run_mode_q == MODE_SINGLE && post;
	endsequence
	sequence hold_read_s;
		state_q == ST_HOLD && rd_res;
	endsequence

	eoc_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		eoc_q && !rd_res && !post |=> eoc_o)
		else $error("end of conversion dropped before read");
	eoc_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		post |=> eoc_o && result_q == $past(post_val) && int_stat_q[INT_DONE])
		else $error("result posted without end of conversion");
	start_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == ST_IDLE && start |=> state_q == ST_FLUSH ##1 (state_q == ST_RUN || $past(stop)))
		else $error("start trigger not taken");
	single_flow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		single_post_s |=> state_q == ST_HOLD)
		else $error("single conversion did not hold");
	hold_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		hold_read_s |=> state_q == ST_IDLE && !eoc_o)
		else $error("single mode did not return to standby");
	single_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
		busy && run_mode_q == MODE_SINGLE && start && !post |=> state_q != ST_FLUSH)
		else $error("trigger restarted a single conversion");
	fast_reflush_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_run && run_mode_q == MODE_FAST && post |=> mod_rst_o ##1 (state_q == ST_RUN || $past(stop)))
		else $error("fast filter did not reset between samples");
	cont_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_run && run_mode_q == MODE_CONT && !stop |=> in_run && !mod_rst_o)
		else $error("continuous mode left running state");
	avg_no_rst_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_run && run_mode_q == MODE_AVG && !stop |=> !mod_rst_o ##1 !mod_rst_o)
		else $error("modulator reset during averaging");
	mode_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		busy |=> $stable(run_mode_q))
		else $error("mode changed during a sequence");

endmodule
`default_nettype wire

// ===== tb/adc_far_model.sv
// Purpose: Far side of the converter: modulator bit source and start strobe
// Assumes: One modulator bit per enable pulse
// Notes:   Bit density is one in four, so any 8-tick window holds two ones
`timescale 1ns/1ps
`default_nettype none
module adc_far_model
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic mod_clk_en_i,
	input  wire logic pace_i,
	output logic      mod_bit_o,
	output logic      soc_o
);
	logic [1:0] phase_q;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			phase_q <= 2'h0;
			soc_o   <= 1'b0;
		end
		else
		begin
			if (mod_clk_en_i)
				phase_q <= phase_q + 2'h1;
			// Strobe stays low unless paced, as in a free-running setup
			soc_o <= pace_i;
		end
	end

	assign mod_bit_o = (phase_q == 2'h0);
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench of the converter sequencer over AHB-Lite
// Assumes: Window shortened to 8 ticks, so each decimator result is 8
// Notes:   Counts modulator reset pulses to tell the modes apart
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import adc_seq_pkg::*;
	logic             clk_i;
	logic             rst_i;
	logic             hsel;
	logic             hwrite;
	logic             pace;
	logic [31:0]      haddr;
	logic [31:0]      hwdata;
	logic [31:0]      hrdata;
	logic [31:0]      rd;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	logic             hreadyout;
	logic             hresp;
	logic             soc;
	logic             mod_bit;
	logic             mod_clk_en;
	logic             mod_rst;
	logic             eoc;
	logic             irq;
	logic [MUX_W-1:0] mux_sel;
	int               num_errors = 0;
	int               num_checks = 0;
	int               flushes = 0;
	int               base;

	adc_sequencer u_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.soc_i(soc), .mod_bit_i(mod_bit), .mod_clk_en_o(mod_clk_en), .mod_rst_o(mod_rst),
		.mux_sel_o(mux_sel), .eoc_o(eoc), .irq_o(irq));

	adc_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .mod_clk_en_i(mod_clk_en),
		.pace_i(pace), .mod_bit_o(mod_bit), .soc_o(soc));

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
		if (mod_rst === 1'b1)
			flushes <= flushes + 1;

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single transfer; entered just after a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		@(posedge clk_i);
		while (hreadyout !== 1'b1) @(posedge clk_i);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wd;
		@(posedge clk_i);
		while (hreadyout !== 1'b1) @(posedge clk_i);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFFFFFF);
		xfer(1'b0, a, 32'h0);
		check(what, exp, rd & m);
	endtask

	task automatic wait_eoc;
		int n;
		n = 0;
		while (eoc !== 1'b1 && n < 400)
		begin
			@(posedge clk_i);
			n++;
		end
		check("eoc high", 32'h1, {31'h0, eoc});
	endtask

	task automatic fire;
		pace <= 1'b1;
		@(posedge clk_i);
		pace <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic results(input int cnt, input logic [31:0] exp);
		repeat (cnt)
		begin
			wait_eoc();
			rdc("result", OFS_RESULT, exp);
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		final_report();
	end

	initial
	begin
		rst_i  = 1'b1;
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
		pace   = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdc("ctrl", OFS_CTRL, 32'h0);
		rdc("status", OFS_STATUS, 32'h0);
		rdc("decim", OFS_DECIM, {16'h0, DECIM_RST});
		rdc("avg", OFS_AVG, {24'h0, AVG_RST});
		rdc("mask", OFS_INT_MASK, 32'h0);
		rdc("unmapped", 8'h1C, 32'h0);
		check("hresp", 32'h0, {31'h0, hresp});
		check("hreadyout", 32'h1, {31'h0, hreadyout});
		check("mod clk en", 32'h1, {31'h0, mod_clk_en});
		wr(OFS_DECIM, 32'h8);
		wr(OFS_AVG, 32'h3);
		wr(OFS_INT_MASK, 32'h1);
		// Single conversion paced by the strobe, second strobe while holding
		base = flushes;
		fire();
		wait_eoc();
		check("irq", 32'h1, {31'h0, irq});
		rdc("status eoc", OFS_STATUS, 32'h1, 32'h1);
		fire();
		repeat (40) @(posedge clk_i);
		check("single flush", base + 1, flushes);
		check("eoc held", 32'h1, {31'h0, eoc});
		rdc("result", OFS_RESULT, 32'h8);
		check("eoc low", 32'h0, {31'h0, eoc});
		rdc("status idle", OFS_STATUS, 32'h0);
		wr(OFS_INT_MASK, 32'h0);
		@(posedge clk_i);
		check("irq masked", 32'h0, {31'h0, irq});
		wr(OFS_INT_MASK, 32'h3);
		wr(OFS_INT_STAT, 32'h3);
		rdc("int clear", OFS_INT_STAT, 32'h0);
		check("irq clear", 32'h0, {31'h0, irq});
		// Fast filter started by the control bit
		base = flushes;
		wr(OFS_CTRL, 32'h101);
		results(3, 32'h8);
		wr(OFS_CTRL, 32'h200);
		check("fast flushes", 32'h1, {31'h0, (flushes - base) >= 3});
		wr(OFS_INT_STAT, 32'h3);
		// Continuous on input 5, strobe left low, then left unread
		base = flushes;
		wr(OFS_CTRL, 32'h116);
		@(posedge clk_i);
		check("mux", 32'h5, {28'h0, mux_sel});
		results(3, 32'h8);
		repeat (20) @(posedge clk_i);
		wr(OFS_CTRL, 32'h200);
		check("cont flushes", base + 1, flushes);
		rdc("busy", OFS_STATUS, 32'h0, 32'h2);
		rdc("overrun", OFS_INT_STAT, 32'h3);
		wr(OFS_INT_STAT, 32'h3);
		// The unread continuous result still stands and is drained here
		rdc("stale result", OFS_RESULT, 32'h8);
		check("eoc drained", 32'h0, {31'h0, eoc});
		// Averaging: three decimator results per output
		base = flushes;
		wr(OFS_CTRL, 32'h103);
		results(2, 32'h18);
		wr(OFS_CTRL, 32'h200);
		check("avg flushes", base + 1, flushes);
		final_report();
	end
endmodule
`default_nettype wire
